// [core/data_transfer_insn_decoder.sv]
// decoder and executor for the data-transfer instruction group
`timescale 1ns/10ps
module data_transfer_insn_decoder (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             insn_valid_i,
  input  wire logic [15:0]      insn_i,
  input  wire logic [31:0]      insn_pc_i,
  output logic                  insn_ready_o,
  output logic                  retire_o,
  output logic                  illegal_o,
  output logic                  priv_violation_o,
  output logic                  sr_flag_we_o,
  input  wire logic             fetch_busy_i,
  output logic                  mem_req_o,
  output xfer_pkg::mem_cmd_t    mem_cmd_o,
  input  wire logic             mem_gnt_i,
  input  wire logic             mem_rvalid_i,
  input  wire logic [31:0]      mem_rdata_i,
  input  wire logic [3:0]       dbg_sel_i,
  output logic      [31:0]      dbg_data_o
);
  import xfer_pkg::*;
  `include "xfer_map.svh"

  logic [3:0]  opc, fld_n, fld_m, sub;
  logic [31:0] val_n, val_m, val_r0;
  logic        legal, is_mem, is_ld;
  logic        rd_n, rd_m, rd_r0;
  size_t       size;
  logic [31:0] addr, sdata;
  logic [3:0]  ld_dst;
  reg_wr_t     wr_a, wr_b, wr_go;
  mem_state_t  st_ff;
  mem_cmd_t    cmd_ff;
  logic        ld_ff;
  size_t       size_ff;
  logic [3:0]  pend_ff;
  logic [31:0] dbg_ff;
  logic        gnt_eff, load_busy, hazard;
  logic        port_free, take;
  logic [31:0] ld_word;

  function automatic logic [31:0] step_of(input size_t s);
    step_of = {29'h0, s == SZ_LONG, s == SZ_WORD, s == SZ_BYTE};
  endfunction : step_of
  function automatic logic [31:0] scale(input logic [7:0] d, input size_t s);
    scale = {24'h0, d} << s;
  endfunction : scale

  assign opc   = insn_i[`XF_OPC_HI:`XF_OPC_LO];
  assign fld_n = insn_i[`XF_DST_HI:`XF_DST_LO];
  assign fld_m = insn_i[`XF_SRC_HI:`XF_SRC_LO];
  assign sub   = insn_i[`XF_SUB_HI:`XF_SUB_LO];
  reg_bank #(.NREG(16)) u_regs (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .rd_a_i (fld_n),
    .rd_b_i (fld_m),
    .rd_c_i (`XF_REG_ZERO),
    .rd_a_o (val_n),
    .rd_b_o (val_m),
    .rd_c_o (val_r0),
    .wr_a_i (wr_go),
    .wr_b_i (wr_b)
  );

  // decode: address, store data, immediate result and read set
  always_comb begin
    legal     = 1'b1;
    is_mem    = 1'b0;
    is_ld     = 1'b0;
    rd_n      = 1'b0;
    rd_m      = 1'b0;
    rd_r0     = 1'b0;
    size      = SZ_LONG;
    addr      = 32'h0;
    sdata     = val_m;
    ld_dst    = fld_n;
    wr_a.we   = 1'b0;
    wr_a.idx  = fld_n;
    wr_a.data = 32'h0;
    case (opc)
      `XF_OPC_IMM: begin
        wr_a.we   = 1'b1;
        wr_a.data = {{24{insn_i[7]}}, insn_i[7:0]};
      end
      `XF_OPC_PCW, `XF_OPC_PCL: begin
        is_mem = 1'b1;
        is_ld  = 1'b1;
        size   = (opc == `XF_OPC_PCW) ? SZ_WORD : SZ_LONG;
        addr   = insn_pc_i + scale(insn_i[7:0], size);
      end
      `XF_OPC_LDGRP: begin
        rd_m = 1'b1;
        if (sub == `XF_SUB_MOVR) begin
          wr_a.we   = 1'b1;
          wr_a.data = val_m;
        end else if (sub[3] == 1'b0 && sub[1:0] != 2'h3) begin
          is_mem = 1'b1;
          is_ld  = 1'b1;
          size   = size_t'(sub[1:0]);
          addr   = val_m;
          if (sub[2]) begin
            wr_a.we   = 1'b1;
            wr_a.idx  = fld_m;
            wr_a.data = val_m + step_of(size);
          end
        end else begin
          legal = 1'b0;
        end
      end
      `XF_OPC_STGRP: begin
        rd_m = 1'b1;
        rd_n = 1'b1;
        if (sub[3] == 1'b0 && sub[1:0] != 2'h3) begin
          is_mem = 1'b1;
          size   = size_t'(sub[1:0]);
          addr   = val_n;
          if (sub[2]) begin
            addr      = val_n - step_of(size);
            wr_a.we   = 1'b1;
            wr_a.data = addr;
          end
        end else begin
          legal = 1'b0;
        end
      end
      `XF_OPC_R0DISP: begin
        // base register sits in bits 7..4 for both directions
        rd_m   = 1'b1;
        is_mem = 1'b1;
        size   = size_t'(insn_i[9:8]);
        addr   = val_m + scale({4'h0, sub}, size);
        ld_dst = `XF_REG_ZERO;
        sdata  = val_r0;
        case (fld_n)
          `XF_R0D_STB, `XF_R0D_STW: rd_r0 = 1'b1;
          `XF_R0D_LDB, `XF_R0D_LDW: is_ld = 1'b1;
          default: begin
            legal  = 1'b0;
            is_mem = 1'b0;
          end
        endcase
      end
      `XF_OPC_STDISP: begin
        rd_m   = 1'b1;
        rd_n   = 1'b1;
        is_mem = 1'b1;
        addr   = val_n + scale({4'h0, sub}, SZ_LONG);
      end
      `XF_OPC_LDDISP: begin
        rd_m   = 1'b1;
        is_mem = 1'b1;
        is_ld  = 1'b1;
        addr   = val_m + scale({4'h0, sub}, SZ_LONG);
      end
      `XF_OPC_IDX: begin
        if (sub == `XF_SUB_IDXB) begin
          rd_m   = 1'b1;
          rd_n   = 1'b1;
          rd_r0  = 1'b1;
          is_mem = 1'b1;
          size   = SZ_BYTE;
          addr   = val_r0 + val_n;
        end else begin
          legal = 1'b0;
        end
      end
      default: legal = 1'b0;
    endcase
    if (!legal) begin
      wr_a.we = 1'b0;
    end
  end

  // a data access waits while the fetch owns the shared path
  assign gnt_eff   = mem_req_o & mem_gnt_i;
  assign mem_req_o = (st_ff == MEM_REQ) & ~fetch_busy_i;
  assign load_busy = (st_ff == MEM_REQ && ld_ff) || st_ff == MEM_WAIT;
  // conservative: any pending load blocks readers and writers of its target
  assign hazard    = load_busy && ((rd_m && fld_m == pend_ff) || (rd_n && fld_n == pend_ff) ||
                     (rd_r0 && pend_ff == `XF_REG_ZERO) ||
                     (wr_a.we && wr_a.idx == pend_ff));
  assign port_free = (st_ff == MEM_IDLE) || (st_ff == MEM_REQ && !ld_ff && gnt_eff);
  // one instruction per cycle at best, never less than one cycle each
  assign insn_ready_o = ce_i && !hazard && (!is_mem || port_free);
  assign take         = insn_valid_i & insn_ready_o;
  // port-a bank writes commit only with a taken word, so a held word never repeats its update
  assign wr_go        = '{we: wr_a.we & take, idx: wr_a.idx, data: wr_a.data};
  assign retire_o     = take;
  assign illegal_o    = take & ~legal;
  assign priv_violation_o = 1'b0;
  assign sr_flag_we_o     = 1'b0;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= MEM_IDLE;
    end else if (ce_i) begin
      case (st_ff)
        MEM_IDLE: begin
          if (take && legal && is_mem) begin
            st_ff <= MEM_REQ;
          end
        end
        MEM_REQ: begin
          if (gnt_eff) begin
            if (ld_ff) begin
              st_ff <= MEM_WAIT;
            end else if (!(take && legal && is_mem)) begin
              st_ff <= MEM_IDLE;
            end
          end
        end
        MEM_WAIT: begin
          if (mem_rvalid_i) begin
            st_ff <= MEM_IDLE;
          end
        end
        default: st_ff <= MEM_IDLE;
      endcase
    end
  end

  // command captured at issue; byte lanes little-endian, only addressed lanes enabled
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_ff  <= '0;
      ld_ff   <= 1'b0;
      size_ff <= SZ_LONG;
      pend_ff <= 4'h0;
    end else if (ce_i && take && legal && is_mem) begin
      ld_ff       <= is_ld;
      size_ff     <= size;
      pend_ff     <= ld_dst;
      cmd_ff.we   <= ~is_ld;
      cmd_ff.addr <= addr;
      case (size)
        SZ_BYTE: begin
          cmd_ff.wdata <= {4{sdata[7:0]}};
          cmd_ff.be    <= 4'h1 << addr[1:0];
        end
        SZ_WORD: begin
          cmd_ff.wdata <= {2{sdata[15:0]}};
          cmd_ff.be    <= addr[1] ? 4'hc : 4'h3;
        end
        default: begin
          cmd_ff.wdata <= sdata;
          cmd_ff.be    <= 4'hf;
        end
      endcase
    end
  end
  assign mem_cmd_o = cmd_ff;

  // return data picked from its lane and extended by access size
  always_comb begin
    ld_word = mem_rdata_i >> {cmd_ff.addr[1:0], 3'h0};
    case (size_ff)
      SZ_BYTE: ld_word = {{24{ld_word[7]}}, ld_word[7:0]};
      SZ_WORD: ld_word = {{16{ld_word[15]}}, ld_word[15:0]};
      default: ld_word = ld_word;
    endcase
  end

  assign wr_b.we   = (st_ff == MEM_WAIT) & mem_rvalid_i;
  assign wr_b.idx  = pend_ff;
  assign wr_b.data = ld_word;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dbg_ff <= 32'h0;
    end else if (ce_i) begin
      dbg_ff <= u_regs.regs_ff[dbg_sel_i];
    end
  end

  assign dbg_data_o = dbg_ff;
endmodule : data_transfer_insn_decoder

// [core/xfer_map.svh]
// opcode fields, sub-operation codes and reset values for the data-transfer decoder
`ifndef XFER_MAP_SVH
`define XFER_MAP_SVH

`define XF_OPC_HI      15
`define XF_OPC_LO      12
`define XF_DST_HI      11
`define XF_DST_LO      8
`define XF_SRC_HI      7
`define XF_SRC_LO      4
`define XF_SUB_HI      3
`define XF_SUB_LO      0

`define XF_OPC_IMM     4'he
`define XF_OPC_PCW     4'h9
`define XF_OPC_PCL     4'hd
`define XF_OPC_LDGRP   4'h6
`define XF_OPC_STGRP   4'h2
`define XF_OPC_R0DISP  4'h8
`define XF_OPC_STDISP  4'h1
`define XF_OPC_LDDISP  4'h5
`define XF_OPC_IDX     4'h0

`define XF_SUB_MOVR    4'h3
`define XF_SUB_IDXB    4'h4
`define XF_R0D_STB     4'h0
`define XF_R0D_STW     4'h1
`define XF_R0D_LDB     4'h4
`define XF_R0D_LDW     4'h5

`define XF_REG_ZERO    4'h0
`define XF_REG_RST     32'h0000_0000
`define XF_MIN_CYCLES  1

`endif

// [core/xfer_pkg.sv]
// types shared by the data-transfer decoder and its register bank
package xfer_pkg;
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } size_t;

  typedef enum logic [1:0] {
    MEM_IDLE = 2'h0,
    MEM_REQ  = 2'h1,
    MEM_WAIT = 2'h3
  } mem_state_t;

  typedef struct packed {
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
  } mem_cmd_t;

  typedef struct packed {
    logic        we;
    logic [3:0]  idx;
    logic [31:0] data;
  } reg_wr_t;
endpackage : xfer_pkg

// [core/reg_bank.sv]
// sixteen general registers, three read ports, two write ports
`timescale 1ns/10ps
module reg_bank #(
  parameter int NREG = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic [3:0]       rd_a_i,
  input  wire logic [3:0]       rd_b_i,
  input  wire logic [3:0]       rd_c_i,
  output logic      [31:0]      rd_a_o,
  output logic      [31:0]      rd_b_o,
  output logic      [31:0]      rd_c_o,
  input  wire xfer_pkg::reg_wr_t wr_a_i,
  input  wire xfer_pkg::reg_wr_t wr_b_i
);
  import xfer_pkg::*;
  `include "xfer_map.svh"

  logic [31:0] regs_ff [NREG];

  // code 0000 is reg_zero, 1111 is register fifteen, counting upward
  assign rd_a_o = regs_ff[rd_a_i];
  assign rd_b_o = regs_ff[rd_b_i];
  assign rd_c_o = regs_ff[rd_c_i];

  // port b carries load returns and wins, so a loaded value beats a post-increment
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NREG; i++) begin
        regs_ff[i] <= `XF_REG_RST;
      end
    end else if (ce_i) begin
      if (wr_a_i.we && !(wr_b_i.we && wr_b_i.idx == wr_a_i.idx)) begin
        regs_ff[wr_a_i.idx] <= wr_a_i.data;
      end
      if (wr_b_i.we) begin
        regs_ff[wr_b_i.idx] <= wr_b_i.data;
      end
    end
  end
endmodule : reg_bank

// [verif/xfer_checker_assertions.sv]
// concurrent checks on the data-transfer decoder ports
`timescale 1ns/10ps
module xfer_checker (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               ce_i,
  input wire logic               insn_valid_i,
  input wire logic [15:0]        insn_i,
  input wire logic [31:0]        insn_pc_i,
  input wire logic               insn_ready_o,
  input wire logic               retire_o,
  input wire logic               priv_violation_o,
  input wire logic               sr_flag_we_o,
  input wire logic               fetch_busy_i,
  input wire logic               mem_req_o,
  input wire xfer_pkg::mem_cmd_t mem_cmd_o
);
  import xfer_pkg::*;
  wire       take = insn_valid_i & insn_ready_o & ce_i;
  wire [3:0] opc  = insn_i[15:12];
  wire [3:0] sub  = insn_i[3:0];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_PRIV: assert property (priv_violation_o == 1'b0)
    else $error("privilege flag raised");
  AST_FLAG: assert property (!sr_flag_we_o)
    else $error("condition flag written");
  AST_CONT: assert property (fetch_busy_i |-> !mem_req_o)
    else $error("request during fetch");
  AST_RET: assert property (take |-> retire_o)
    else $error("taken but not retired");
  AST_REQ: assert property (take && opc == 4'hd |=> mem_req_o || fetch_busy_i)
    else $error("load request late");
  AST_PCW: assert property (take && opc == 4'h9 |=> !mem_cmd_o.we &&
    mem_cmd_o.addr == $past(insn_pc_i) + {23'h0, $past(insn_i[7:0]), 1'b0})
    else $error("pc word address wrong");
  AST_PCL: assert property (take && opc == 4'hd |=>
    mem_cmd_o.addr == $past(insn_pc_i) + {22'h0, $past(insn_i[7:0]), 2'b00})
    else $error("pc long address wrong");
  AST_STL: assert property (take && opc == 4'h2 && sub == 4'h6 |=>
    mem_cmd_o.we && mem_cmd_o.be == 4'hf)
    else $error("long store lanes wrong");
  AST_STB: assert property (take && (opc == 4'h2 || opc == 4'h0) && sub == 4'h4 |=>
    mem_cmd_o.be == 4'h1 << mem_cmd_o.addr[1:0])
    else $error("byte store lanes wrong");
  AST_STW: assert property (take && opc == 4'h2 && sub == 4'h5 |=>
    mem_cmd_o.be == (mem_cmd_o.addr[1] ? 4'hc : 4'h3))
    else $error("word store lanes wrong");
endmodule : xfer_checker

bind data_transfer_insn_decoder xfer_checker u_chk (.*);

// [verif/mem_model.sv]
// data memory partner: grants at once, returns load data after lat cycles
`timescale 1ns/10ps
module mem_model (
  input  wire logic               clk_i,
  input  wire logic               req_i,
  input  wire xfer_pkg::mem_cmd_t cmd_i,
  output logic                    gnt_o,
  output logic                    rvalid_o = 1'b0,
  output logic [31:0]             rdata_o = 32'h0
);
  import xfer_pkg::*;
  int       lat  = 1;
  int       cnt  = 0;
  int       ngnt = 0;
  mem_cmd_t last_cmd;
  assign gnt_o = req_i;
  always @(posedge clk_i) begin
    rvalid_o <= 1'b0;
    // idle data toggles so stale data never passes for a result
    rdata_o <= ~rdata_o;
    if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        rvalid_o <= 1'b1;
        rdata_o  <= 32'h80f1_7f92;
      end
    end
    if (req_i & gnt_o) begin
      ngnt     <= ngnt + 1;
      last_cmd <= cmd_i;
      if (!cmd_i.we) cnt <= lat;
    end
  end
endmodule : mem_model

// [verif/tb_top.sv]
// self-checking bench for the data-transfer decoder
`timescale 1ns/10ps
module tb_top;
  import xfer_pkg::*;
  localparam logic [31:0] MEMW = 32'h80f1_7f92;
  logic        clk_i = 0, rst_i = 1, ce_i = 1, insn_valid_i = 0, fetch_busy_i = 0;
  logic [15:0] insn_i = 16'h0;
  logic [31:0] insn_pc_i = 32'h0;
  logic [3:0]  dbg_sel_i = 4'h0;
  logic        insn_ready_o, retire_o, illegal_o, priv_violation_o, sr_flag_we_o;
  logic        mem_req_o, mem_gnt_i, mem_rvalid_i;
  logic [31:0] mem_rdata_i, dbg_data_o;
  mem_cmd_t    mem_cmd_o;
  int          error_cnt = 0, checked = 0, wait_n;

  data_transfer_insn_decoder u_dut (.*);
  mem_model u_mem (.clk_i(clk_i), .req_i(mem_req_o), .cmd_i(mem_cmd_o), .gnt_o(mem_gnt_i),
                   .rvalid_o(mem_rvalid_i), .rdata_o(mem_rdata_i));

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp

  // leaves valid up so back-to-back words need no gap
  task automatic issue(input logic [15:0] w);
    wait_n = 0;
    insn_i <= w;
    insn_valid_i <= 1'b1;
    @(negedge clk_i);
    while (insn_ready_o !== 1'b1 && wait_n < 50) begin
      wait_n++;
      @(negedge clk_i);
    end
    if (wait_n >= 50) begin
      error_cnt++;
      $display("BAD %0t no ready", $time);
    end
    @(posedge clk_i);
  endtask : issue

  task automatic chkr(input logic [3:0] r, input logic [31:0] exp);
    insn_valid_i <= 1'b0;
    dbg_sel_i <= r;
    repeat (2) @(negedge clk_i);
    for (int i = 0; i < 20 && dbg_data_o !== exp; i++) @(negedge clk_i);
    cmp(dbg_data_o, exp);
    @(posedge clk_i);
  endtask : chkr

  task automatic chkm(input logic w, input logic [31:0] a, d, input logic [3:0] b);
    int ng;
    ng = u_mem.ngnt;
    insn_valid_i <= 1'b0;
    for (int i = 0; i < 20 && u_mem.ngnt == ng; i++) @(negedge clk_i);
    if (u_mem.ngnt == ng) begin
      error_cnt++;
      $display("BAD %0t no grant", $time);
    end
    cmp({31'h0, u_mem.last_cmd.we}, {31'h0, w});
    cmp(u_mem.last_cmd.addr, a);
    if (w) begin
      cmp(u_mem.last_cmd.wdata, d);
      cmp({28'h0, u_mem.last_cmd.be}, {28'h0, b});
    end
    @(posedge clk_i);
  endtask : chkm

  task automatic t_imm;
    issue(16'he105);
    cmp(wait_n, 0);
    issue(16'heff0);
    issue(16'he010);
    insn_i <= 16'h3123;
    @(negedge clk_i);
    cmp({30'h0, illegal_o, retire_o}, 32'h3);
    @(posedge clk_i);
    ce_i   <= 1'b0;
    insn_i <= 16'he1aa;
    @(negedge clk_i);
    cmp({31'h0, insn_ready_o}, 32'h0);
    @(posedge clk_i);
    ce_i <= 1'b1;
    chkr(4'h1, 32'h5);
    chkr(4'hf, 32'hffff_fff0);
    chkr(4'h0, 32'h10);
    $display("imm done");
  endtask : t_imm

  task automatic t_pc;
    insn_pc_i <= 32'h100;
    issue(16'h9303);
    chkm(0, 32'h106, 0, 0);
    chkr(4'h3, 32'hffff_80f1);
    issue(16'hd401);
    chkm(0, 32'h104, 0, 0);
    chkr(4'h4, MEMW);
    $display("pc done");
  endtask : t_pc

  task automatic t_ind;
    issue(16'he623);
    issue(16'h6a64);
    chkm(0, 32'h23, 0, 0);
    chkr(4'ha, 32'hffff_ff80);
    chkr(4'h6, 32'h24);
    issue(16'h6861);
    chkr(4'h8, 32'h7f92);
    issue(16'h6962);
    chkr(4'h9, MEMW);
    $display("ind done");
  endtask : t_ind

  task automatic t_st;
    issue(16'he220);
    issue(16'he781);
    issue(16'h2276);
    chkm(1, 32'h1c, 32'hffff_ff81, 4'hf);
    issue(16'h2275);
    chkm(1, 32'h1a, 32'hff81_ff81, 4'hc);
    issue(16'h2274);
    chkm(1, 32'h19, 32'h8181_8181, 4'h2);
    chkr(4'h2, 32'h19);
    $display("st done");
  endtask : t_st

  task automatic t_disp;
    issue(16'he104);
    issue(16'h8012);
    chkm(1, 32'h6, 32'h1010_1010, 4'h4);
    issue(16'h8112);
    chkm(1, 32'h8, 32'h0010_0010, 4'h3);
    issue(16'h1172);
    chkm(1, 32'hc, 32'hffff_ff81, 4'hf);
    issue(16'h5d11);
    chkr(4'hd, MEMW);
    issue(16'h8513);
    chkm(0, 32'ha, 0, 0);
    chkr(4'h0, 32'hffff_80f1);
    issue(16'h0174);
    chkm(1, 32'hffff_80f5, 32'h8181_8181, 4'h2);
    $display("disp done");
  endtask : t_disp

  // fetch contention, then a slow load followed by a reader
  task automatic t_hz;
    fetch_busy_i <= 1'b1;
    issue(16'h2276);
    insn_valid_i <= 1'b0;
    repeat (4) @(negedge clk_i);
    cmp({31'h0, mem_req_o}, 32'h0);
    @(posedge clk_i);
    fetch_busy_i <= 1'b0;
    chkm(1, 32'h15, 32'hffff_ff81, 4'hf);
    u_mem.lat = 6;
    issue(16'he640);
    issue(16'h6a62);
    issue(16'h6ba3);
    cmp({31'h0, wait_n > 3}, 32'h1);
    chkr(4'hb, MEMW);
    $display("hz done");
  endtask : t_hz

  task automatic complete_run;
    $display("checked %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  initial begin
    #200000;
    error_cnt++;
    $display("BAD %0t watchdog", $time);
    complete_run();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_imm();
    t_pc();
    t_ind();
    t_st();
    t_disp();
    t_hz();
    complete_run();
  end
endmodule : tb_top
